//--- shared/dacbp_pkg.sv
`default_nettype none
package dacbp_pkg;
	// channel bank shape
	localparam int CHAN_COUNT = 8;                   // output channels on the board
	localparam int CODE_W     = 8;                   // bits per channel code
	localparam int SEL_W      = 3;                   // channel select width
	localparam int ADDR_W     = 6;                   // cable location address width
	localparam int LOC_COUNT  = 64;                  // addressable cable locations

	// status byte layout on a pointer read
	localparam int STAT_BUSY_BIT  = 7;               // conversion in progress
	localparam int STAT_WRACT_BIT = 6;               // write-active window
	localparam int STAT_ADDR_LSB  = 0;               // latched address field base

	// master clear value of every latch; reset value of the pointer
	localparam logic [CODE_W-1:0] CODE_CLEAR = 8'h00;
	localparam logic [ADDR_W-1:0] PTR_RESET  = 6'h00;

	// timing
	localparam int CLK_PERIOD_NS  = 100;             // 10 MHz system clock
	localparam int WRACT_TIME_US  = 10;              // write-active window
	localparam int BUSY_TIME_NS   = 80;              // conversion settle time
	// a fixed window: rounded down to whole cycles, never below one
	localparam int WRACT_CYCLES_I = (WRACT_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int WRACT_CYCLES   = (WRACT_CYCLES_I < 1) ? 1 : WRACT_CYCLES_I;
	// a settle time is a least time: rounded up
	localparam int BUSY_CYCLES    = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRACT_CNT_W    = $clog2(WRACT_CYCLES + 1);
	localparam int BUSY_CNT_W     = $clog2(BUSY_CYCLES + 1);

	// width of the synchronised pin bundle
	localparam int PIN_W = 5 + CODE_W + ADDR_W;

	// write-active window state
	typedef enum logic [0:0]
	{
		WRACT_IDLE   = 1'b0,
		WRACT_ACTIVE = 1'b1
	} dacbp_wract_t;
endpackage
`default_nettype wire

//--- shared/dacbp_latch_if.sv
`default_nettype none
interface dacbp_latch_if;
	logic                                                       wrEn;     // load one latch
	logic [dacbp_pkg::SEL_W-1:0]                                wrSel;    // latch to load
	logic [dacbp_pkg::CODE_W-1:0]                               wrCode;   // code to load
	logic                                                       clearAll; // master clear
	logic [dacbp_pkg::SEL_W-1:0]                                rdSel;    // latch to read back
	logic [dacbp_pkg::CODE_W-1:0]                               rdCode;   // readback value
	logic [dacbp_pkg::CHAN_COUNT-1:0][dacbp_pkg::CODE_W-1:0]    codes;    // all latch outputs

	modport bank (input wrEn, wrSel, wrCode, clearAll, rdSel, output rdCode, codes);
	modport ctrl (output wrEn, wrSel, wrCode, clearAll, rdSel, input rdCode, codes);
endinterface
`default_nettype wire

//--- hw/dacbp_channel_bank.sv
`default_nettype none
module dacbp_channel_bank
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// latch access
	dacbp_latch_if.bank     lat
);
	// one byte latch per channel, each bit stored on its own
	logic [dacbp_pkg::CHAN_COUNT-1:0][dacbp_pkg::CODE_W-1:0] code_reg;  // latch contents
	logic [dacbp_pkg::CHAN_COUNT-1:0][dacbp_pkg::CODE_W-1:0] code_next; // next contents

	// next latch values: clear beats a write arriving with it
	always_comb
	begin
		code_next = code_reg;
		if (lat.clearAll)
		begin
			for (int i = 0; i < dacbp_pkg::CHAN_COUNT; i++)
				code_next[i] = dacbp_pkg::CODE_CLEAR;
		end
		else if (lat.wrEn)
		begin
			// only the selected latch moves, every bit taken as written
			code_next[lat.wrSel] = lat.wrCode;
		end
	end

	// latch registers
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			for (int i = 0; i < dacbp_pkg::CHAN_COUNT; i++)
				code_reg[i] <= dacbp_pkg::CODE_CLEAR;
		end
		else
			code_reg <= code_next;
	end

	// readback and converter feeds; codes go out unchanged, the analog side sets the format
	assign lat.rdCode = code_reg[lat.rdSel];
	assign lat.codes  = code_reg;
endmodule // dacbp_channel_bank
`default_nettype wire

//--- hw/dacbp_bus_port.sv
`default_nettype none
// Function
// - data read returns selected channel latch
// - every latch bit writable and readable
// - pointer read gives busy, write-active, address
// - write-active high ten microseconds per write
// - busy high one clock, at least one conversion time
// - board answers eight locations from base
// - master clear zeroes all channel latches
// - codes straight or offset binary, passed unchanged
module dacbp_bus_port
(
	// clock and reset
	input  wire logic                                               clk,
	input  wire logic                                               reset,
	// cable strobes, high during the access
	input  wire logic                                               pointerWrite,
	input  wire logic                                               pointerRead,
	input  wire logic                                               dataWrite,
	input  wire logic                                               dataRead,
	input  wire logic                                               masterClear,
	// cable data lines
	input  wire logic [dacbp_pkg::CODE_W-1:0]                       busDataIn,
	output logic      [dacbp_pkg::CODE_W-1:0]                       busDataOut,
	output logic                                                    busDataOe,
	// board address switch
	input  wire logic [dacbp_pkg::ADDR_W-1:0]                       boardAddress,
	// converter feeds and status
	output logic      [dacbp_pkg::CHAN_COUNT-1:0][dacbp_pkg::CODE_W-1:0] channelCode,
	output logic                                                    busyFlag,
	output logic                                                    writeActive
);
	// synchroniser stages for every pin; stage A is read only by stage B
	logic [dacbp_pkg::PIN_W-1:0]       syncA_reg;     // first stage
	logic [dacbp_pkg::PIN_W-1:0]       syncB_reg;     // second stage
	logic [3:0]                        strobePrev_reg; // strobe history for edges
	logic [dacbp_pkg::PIN_W-1:0]       syncA_next;    // pins as seen this cycle
	logic [dacbp_pkg::PIN_W-1:0]       syncB_next;    // next second stage
	logic [3:0]                        strobePrev_next; // next strobe history

	// synchronised pins
	logic                              ptrWrS;        // pointer write strobe
	logic                              ptrRdS;        // pointer read strobe
	logic                              dataWrS;       // data write strobe
	logic                              dataRdS;       // data read strobe
	logic                              clearS;        // master clear level
	logic [dacbp_pkg::CODE_W-1:0]      dataS;         // data lines
	logic [dacbp_pkg::ADDR_W-1:0]      boardS;        // switch setting
	logic                              ptrWrRise;     // pointer write taken
	logic                              dataWrRise;    // data write taken
	logic                              selected;      // pointer lands on this board

	// access state
	logic [dacbp_pkg::ADDR_W-1:0]      pointer_reg;   // latched location address
	logic [dacbp_pkg::ADDR_W-1:0]      pointer_next;
	dacbp_pkg::dacbp_wract_t           wract_reg;     // write-active window
	dacbp_pkg::dacbp_wract_t           wract_next;
	logic [dacbp_pkg::WRACT_CNT_W-1:0] wractCount_reg; // cycles left in window
	logic [dacbp_pkg::WRACT_CNT_W-1:0] wractCount_next;
	logic [dacbp_pkg::BUSY_CNT_W-1:0]  busyCount_reg; // cycles left converting
	logic [dacbp_pkg::BUSY_CNT_W-1:0]  busyCount_next;
	logic [dacbp_pkg::CODE_W-1:0]      dataOut_reg;   // value driven on reads
	logic [dacbp_pkg::CODE_W-1:0]      dataOut_next;
	logic                              dataOe_reg;    // drive enable on reads
	logic                              dataOe_next;
	logic                              busy_reg;      // status copy of busy
	logic                              busy_next;
	logic                              wractBit_reg;  // status copy of write-active
	logic                              wractBit_next;
	logic [dacbp_pkg::CODE_W-1:0]      status;        // status byte image

	dacbp_latch_if lat ();

	// latch bank
	dacbp_channel_bank u_bank
	(
		.clk   (clk),
		.reset (reset),
		.lat   (lat)
	);

	// next synchroniser values; two stages cost two cycles of latency but keep
	// a metastable pin sample out of every decode
	always_comb
	begin
		syncA_next      = {pointerWrite, pointerRead, dataWrite, dataRead, masterClear,
			busDataIn, boardAddress};
		syncB_next      = syncA_reg;
		strobePrev_next = syncB_reg[dacbp_pkg::PIN_W-1 -: 4];
	end

	// pin synchroniser registers; data shares the strobe latency so it is
	// settled by the time the strobe edge is seen, provided the host holds it
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			syncA_reg      <= '0;
			syncB_reg      <= '0;
			strobePrev_reg <= '0;
		end
		else
		begin
			syncA_reg      <= syncA_next;
			syncB_reg      <= syncB_next;
			strobePrev_reg <= strobePrev_next;
		end
	end

	// unpack the second stage
	assign {ptrWrS, ptrRdS, dataWrS, dataRdS, clearS, dataS, boardS} = syncB_reg;
	// history bits: 3 pointer write, 2 pointer read, 1 data write, 0 data read;
	// history resets low, matching idle strobes, so no false edge follows reset
	assign ptrWrRise  = ptrWrS & ~strobePrev_reg[3];
	assign dataWrRise = dataWrS & ~strobePrev_reg[1];
	// eight locations from the base; the low switch bits are ignored
	assign selected   = (pointer_reg[dacbp_pkg::ADDR_W-1:dacbp_pkg::SEL_W]
		== boardS[dacbp_pkg::ADDR_W-1:dacbp_pkg::SEL_W]);

	// status byte image
	always_comb
	begin
		status = '0;
		status[dacbp_pkg::STAT_BUSY_BIT]  = busy_reg;
		status[dacbp_pkg::STAT_WRACT_BIT] = wractBit_reg;
		status[dacbp_pkg::STAT_ADDR_LSB +: dacbp_pkg::ADDR_W] = pointer_reg;
	end

	// next access state
	always_comb
	begin
		pointer_next    = pointer_reg;
		wract_next      = wract_reg;
		wractCount_next = wractCount_reg;
		busyCount_next  = busyCount_reg;
		dataOut_next    = dataOut_reg;
		dataOe_next     = 1'b0;
		lat.wrEn        = 1'b0;
		lat.wrSel       = pointer_reg[dacbp_pkg::SEL_W-1:0];
		lat.wrCode      = dataS;
		lat.clearAll    = clearS;
		lat.rdSel       = pointer_reg[dacbp_pkg::SEL_W-1:0];
		// pointer changes only on its own write
		if (ptrWrRise)
			pointer_next = dataS[dacbp_pkg::ADDR_W-1:0];
		// limitation: a write inside the window restarts it; the host must poll first
		// a data write for this board loads a latch and opens both windows
		if (dataWrRise && selected)
		begin
			lat.wrEn        = 1'b1;
			wract_next      = dacbp_pkg::WRACT_ACTIVE;
			wractCount_next = dacbp_pkg::WRACT_CNT_W'(dacbp_pkg::WRACT_CYCLES);
			busyCount_next  = dacbp_pkg::BUSY_CNT_W'(dacbp_pkg::BUSY_CYCLES);
		end
		else
		begin
			// window counts down and falls back to quiescent low
			unique case (wract_reg)
				dacbp_pkg::WRACT_IDLE:
					wractCount_next = '0;
				dacbp_pkg::WRACT_ACTIVE:
				begin
					wractCount_next = wractCount_reg - 1'b1;
					if (wractCount_reg == dacbp_pkg::WRACT_CNT_W'(1))
						wract_next = dacbp_pkg::WRACT_IDLE;
				end
			endcase
			if (busyCount_reg != '0)
				busyCount_next = busyCount_reg - 1'b1;
		end
		// reads drive the lines while the strobe stays high; the status read is
		// always answered so a polling host never sees a floating bus
		if (ptrRdS)
		begin
			dataOe_next  = 1'b1;
			dataOut_next = status;
		end
		else if (dataRdS && selected)
		begin
			dataOe_next  = 1'b1;
			dataOut_next = lat.rdCode;
		end
		// status copies follow the counters' next values, so the status byte and
		// the flag pins never disagree in any cycle
		busy_next     = (busyCount_next != '0);
		wractBit_next = (wract_next == dacbp_pkg::WRACT_ACTIVE);
	end

	// access state registers
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			pointer_reg    <= dacbp_pkg::PTR_RESET;
			wract_reg      <= dacbp_pkg::WRACT_IDLE;
			wractCount_reg <= '0;
			busyCount_reg  <= '0;
			dataOut_reg    <= '0;
			dataOe_reg     <= 1'b0;
			busy_reg       <= 1'b0;
			wractBit_reg   <= 1'b0;
		end
		else
		begin
			pointer_reg    <= pointer_next;
			wract_reg      <= wract_next;
			wractCount_reg <= wractCount_next;
			busyCount_reg  <= busyCount_next;
			dataOut_reg    <= dataOut_next;
			dataOe_reg     <= dataOe_next;
			busy_reg       <= busy_next;
			wractBit_reg   <= wractBit_next;
		end
	end

	// outputs, all straight from flip-flops
	assign busDataOut  = dataOut_reg;
	assign busDataOe   = dataOe_reg;
	assign channelCode = lat.codes;
	assign busyFlag    = busy_reg;
	assign writeActive = wractBit_reg;
endmodule // dacbp_bus_port
`default_nettype wire

//--- tb/dacbp_bus_port_props.sv
`default_nettype none
module dacbp_bus_port_props
(
	// clock and reset
	input wire logic                        clk,
	input wire logic                        reset,
	// cable strobes
	input wire logic                        dataWrite,
	input wire logic                        pointerRead,
	input wire logic                        dataRead,
	input wire logic                        masterClear,
	// board outputs
	input wire logic                        busDataOe,
	input wire logic [7:0][7:0]             channelCode,
	input wire logic                        busyFlag,
	input wire logic                        writeActive
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]      winCnt_reg;   // cycles since the window opened
	logic [7:0]      winCnt_next;
	logic [7:0][7:0] prevCode_reg; // codes one cycle ago
	logic [7:0][7:0] prevCode_next;
	logic [7:0]      chgMask;      // channels that just changed
	// a retrigger restarts the count, so only the last window is timed
	always_comb
	begin
		winCnt_next = busyFlag ? 8'h01 : (writeActive ? winCnt_reg + 8'h01 : winCnt_reg);
		prevCode_next = channelCode;
		for (int i = 0; i < 8; i++)
			chgMask[i] = channelCode[i] != prevCode_reg[i];
	end
	// helper registers
	always_ff @(posedge clk)
	begin
		winCnt_reg <= reset ? 8'h00 : winCnt_next;
		prevCode_reg <= reset ? '0 : prevCode_next;
	end
	a_busy_one_pulse: assert property (@(posedge clk) disable iff (reset)
		busyFlag |=> !busyFlag) else $error("busy longer than one cycle");
	a_busy_in_window: assert property (@(posedge clk) disable iff (reset)
		busyFlag |-> writeActive) else $error("busy outside write window");
	a_wract_length: assert property (@(posedge clk) disable iff (reset)
		$fell(writeActive) |-> winCnt_reg == 8'h64) else $error("write window length");
	a_wract_bound: assert property (@(posedge clk) disable iff (reset)
		writeActive && !busyFlag |-> winCnt_reg < 8'h64) else $error("write window too long");
	a_code_needs_write: assert property (@(posedge clk) disable iff (reset)
		$changed(channelCode) |-> busyFlag || channelCode == '0) else $error("stray code change");
	a_one_channel: assert property (@(posedge clk) disable iff (reset)
		busyFlag |-> $onehot0(chgMask)) else $error("several channels changed");
	a_busy_cause: assert property (@(posedge clk) disable iff (reset)
		$rose(busyFlag) |-> $past(dataWrite, 3)) else $error("busy without data write");
	a_oe_on_read: assert property (@(posedge clk) disable iff (reset)
		$rose(pointerRead) |-> ##3 busDataOe) else $error("status not driven");
	a_oe_release: assert property (@(posedge clk) disable iff (reset)
		$fell(pointerRead) || $fell(dataRead) |-> ##3 !busDataOe) else $error("drive held");
	a_clear_zeroes: assert property (@(posedge clk) disable iff (reset)
		masterClear [*6] |-> channelCode == '0) else $error("clear did not zero");
endmodule // dacbp_bus_port_props
bind dacbp_bus_port dacbp_bus_port_props u_props (.clk(clk), .reset(reset),
	.dataWrite(dataWrite), .pointerRead(pointerRead), .dataRead(dataRead),
	.masterClear(masterClear), .busDataOe(busDataOe), .channelCode(channelCode),
	.busyFlag(busyFlag), .writeActive(writeActive));
`default_nettype wire

//--- tb/dacbp_host_model.sv
`default_nettype none
module dacbp_host_model
(
	// clock
	input wire logic        clk,
	// cable strobes
	output logic            pointerWrite,
	output logic            pointerRead,
	output logic            dataWrite,
	output logic            dataRead,
	output logic            masterClear,
	// cable data lines
	output logic [7:0]      busDataIn,
	input wire logic [7:0]  busDataOut,
	input wire logic        busDataOe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] strb = 5'h00; // one strobe per access kind
	assign {pointerWrite, pointerRead, dataWrite, dataRead, masterClear} = strb;
	initial busDataIn = 8'hff;
	// kind 0 ptr write, 1 ptr read, 2 data write, 3 data read, 4 clear;
	// data leads and trails the strobe so the synchronisers see it settled
	task automatic access(input int k, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk) #5 busDataIn = d;
		@(posedge clk) #5 strb = 5'h10 >> k;
		repeat (7) @(posedge clk);
		#5 q = busDataOe ? busDataOut : 8'hxx;
		strb = 5'h00;
		repeat (3) @(posedge clk);
		// released lines show the inverse, not a stale value
		#5 busDataIn = ~d;
		repeat (2) @(posedge clk);
	endtask
	// only status reads while the write window is open; the last status is
	// handed back so the caller can flag a window that never closed
	task automatic waitIdle(output logic [7:0] q);
		for (int n = 0; n < 40; n++)
		begin
			access(1, 8'h00, q);
			if ((q & 8'h40) === 8'h00) return;
		end
	endtask
	// bipolar code, span already doubled by the caller
	function automatic logic [7:0] biCode(input int mv, input int spanMv);
		return 8'((mv * 256) / spanMv + 128);
	endfunction
endmodule // dacbp_host_model
`default_nettype wire

//--- tb/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic reset = 1'b1;
	wire logic pWr, pRd, dWr, dRd, mClr, oe, busy, wact;
	wire logic [7:0] dIn, dOut;
	wire logic [7:0][7:0] chanCode;
	logic [7:0] exp [8] = '{default: 8'h00}; // expected latch contents
	int num_errors = 0;
	int checked = 0;
	int wrRun = 0;   // current write window length
	int lastRun = 0; // length of the last finished window
	always #50 clk = ~clk;
	dacbp_host_model host (.clk(clk), .pointerWrite(pWr), .pointerRead(pRd),
		.dataWrite(dWr), .dataRead(dRd), .masterClear(mClr), .busDataIn(dIn),
		.busDataOut(dOut), .busDataOe(oe));
	dacbp_bus_port dut (.clk(clk), .reset(reset), .pointerWrite(pWr), .pointerRead(pRd),
		.dataWrite(dWr), .dataRead(dRd), .masterClear(mClr), .busDataIn(dIn),
		.busDataOut(dOut), .busDataOe(oe), .boardAddress(6'h20), .channelCode(chanCode),
		.busyFlag(busy), .writeActive(wact));
	// measure each write window
	always @(posedge clk)
	begin
		if (wact === 1'b1) wrRun++;
		else if (wrRun != 0)
		begin
			lastRun = wrRun;
			wrRun = 0;
		end
	end
	task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic chkBank;
		for (int i = 0; i < 8; i++) check("channel code", exp[i], chanCode[i]);
	endtask
	task automatic print_verdict;
		if (num_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// status and latches straight after reset
	task automatic t_reset;
		logic [7:0] q;
		host.access(1, 8'h00, q);
		check("status", 8'h00, q);
		chkBank();
	endtask
	// every channel, full scale and mid codes, status and readback
	task automatic t_write_all;
		logic [7:0] q;
		logic [7:0] v [8] = '{8'hff, 8'h80, 8'h00, 8'h5a, 8'ha5, 8'h01, 8'h7f, 8'h00};
		v[7] = host.biCode(3260, 10000);
		for (int c = 0; c < 8; c++)
		begin
			host.access(0, 8'(8'h20 + c), q);
			host.access(2, v[c], q);
			exp[c] = v[c];
			host.access(1, 8'h00, q);
			check("status", 8'(8'h60 + c), q);
			host.waitIdle(q);
			check("write active", 8'h00, q & 8'h40);
			check("window", 8'h64, 8'(lastRun));
			host.access(3, 8'h00, q);
			check("readback", v[c], q);
			chkBank();
		end
	endtask
	// walk a single one through channel 3, pointer written once
	task automatic t_bits;
		logic [7:0] q;
		host.access(0, 8'h23, q);
		for (int b = 0; b < 8; b++)
		begin
			host.access(2, 8'h01 << b, q);
			host.waitIdle(q);
			check("write active", 8'h00, q & 8'h40);
			host.access(3, 8'h00, q);
			check("bit readback", 8'h01 << b, q);
		end
		exp[3] = 8'h80;
		chkBank();
	endtask
	// locations just below and above the board are ignored
	task automatic t_foreign;
		logic [7:0] q;
		for (int a = 0; a < 2; a++)
		begin
			host.access(0, a ? 8'h28 : 8'h1f, q);
			host.access(2, 8'h3c, q);
			host.access(1, 8'h00, q);
			check("foreign status", a ? 8'h28 : 8'h1f, q);
			host.access(3, 8'h00, q);
			check("foreign read", 8'hxx, q);
		end
		chkBank();
	endtask
	// master clear zeroes latches, keeps pointer
	task automatic t_clear;
		logic [7:0] q;
		host.access(0, 8'h25, q);
		host.access(4, 8'h00, q);
		exp = '{default: 8'h00};
		chkBank();
		host.access(1, 8'h00, q);
		check("status after clear", 8'h25, q);
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		#5 reset = 1'b0;
		t_reset();
		t_write_all();
		t_bits();
		t_foreign();
		t_clear();
		print_verdict();
	end
	// about three and a half times the expected run
	initial
	begin
		#800000;
		num_errors++;
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
